/* design/tctp_pkg.sv */
package tctp_pkg;
	localparam logic [7:0] CMD_START      = 8'h51;
	localparam logic [7:0] CMD_STOP       = 8'h22;
	localparam logic [7:0] CMD_READ_TEMP  = 8'hAA;
	localparam logic [7:0] CMD_FETCH_HIGH = 8'hA1;
	localparam logic [7:0] CMD_FETCH_LOW  = 8'hA2;
	localparam logic [7:0] CMD_LOAD_HIGH  = 8'h01;
	localparam logic [7:0] CMD_LOAD_LOW   = 8'h02;
	localparam logic [7:0] CMD_READ_CFG   = 8'hAC;
	localparam logic [7:0] CMD_WRITE_CFG  = 8'h0C;
	localparam logic [7:0] CMD_SOFT_POR   = 8'h54;
	localparam int CMD_BITS   = 8;
	localparam int THR_BITS   = 12;
	localparam int CFG_BITS   = 8;
	localparam int WORD_BITS  = 16;
	localparam int DONE_POS   = 7;
	localparam int THF_POS    = 6;
	localparam int TLF_POS    = 5;
	localparam int NVB_POS    = 4;
	localparam int RES_HI_POS = 3;
	localparam int RES_LO_POS = 2;
	localparam int CPU_POS    = 1;
	localparam int SHOT_POS   = 0;
	localparam logic [7:0]  CFG_RESET  = 8'h8C;
	localparam logic [11:0] HIGH_RESET = 12'h000;
	localparam logic [11:0] LOW_RESET  = 12'h000;
	localparam logic [15:0] TEMP_RESET = 16'h0000;
	localparam int CLK_HZ        = 20000000;
	localparam int CONV_TIME_US  = 93750;
	localparam int CONV_CYCLES   = int'((64'(CONV_TIME_US) * 64'(CLK_HZ)) / 64'd1000000);
	localparam int NV_TIME_US    = 10000;
	localparam int NV_CYCLES     = int'((64'(NV_TIME_US) * 64'(CLK_HZ)) / 64'd1000000);
	localparam int TIMER_W       = 25;
	typedef enum logic [3:0]
	{
		TCTP_CMD   = 4'b0001,
		TCTP_WRITE = 4'b0010,
		TCTP_READ  = 4'b0100,
		TCTP_IDLE  = 4'b1000
	} tctp_state_t;
endpackage : tctp_pkg

/* design/tctp_port.sv */
`timescale 1ns/10ps
`default_nettype none
module tctp_port
#(
	parameter int CONV_BASE = tctp_pkg::CONV_CYCLES,
	parameter int NV_BASE   = tctp_pkg::NV_CYCLES
)
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// three-wire link
	input  wire logic        sel_pin,
	input  wire logic        sclk_pin,
	input  wire logic        dq_in,
	output logic             dq_out,
	output logic             dq_oe,
	// temperature source
	input  wire logic [15:0] temp_sample,
	// status
	output logic             converting,
	output logic             nonvolatile_busy_flag,
	output logic [7:0]       config_value,
	output logic [11:0]      high_threshold,
	output logic [11:0]      low_threshold,
	output logic [15:0]      temp_result
);
	import tctp_pkg::*;

	logic [1:0]  sel_sync;
	logic        wr_commit;
	logic [2:0]  sclk_sync;
	logic [1:0]  dq_sync;
	logic        sel_s;
	logic        sclk_rise;
	logic        sclk_fall;
	tctp_state_t state;
	logic [7:0]  cmd_shift;
	logic [3:0]  cmd_count;
	logic [11:0] wr_shift;
	logic [4:0]  bit_count;
	logic [15:0] rd_shift;
	logic [4:0]  rd_len;
	logic        cmd_done;
	logic [7:0]  cmd_full;
	logic        soft_por;
	logic        conv_continuous;
	logic [TIMER_W-1:0] conv_timer;
	logic [TIMER_W-1:0] conv_len;
	logic [TIMER_W-1:0] nv_timer;
	logic        start_req;
	logic        stop_req;
	logic        thf;
	logic        tlf;
	logic [1:0]  res_code;

	// first stage read only by the second
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sel_sync  <= 2'h0;
			sclk_sync <= 3'h0;
			dq_sync   <= 2'h0;
		end
		else
		begin
			sel_sync  <= {sel_sync[0], sel_pin};
			sclk_sync <= {sclk_sync[1:0], sclk_pin};
			dq_sync   <= {dq_sync[0], dq_in};
		end
	end

	assign sel_s     = sel_sync[1];
	assign sclk_rise = sel_s && sclk_sync[1] && !sclk_sync[2];
	assign sclk_fall = sel_s && !sclk_sync[1] && sclk_sync[2];
	assign cmd_full  = {dq_sync[1], cmd_shift[7:1]};
	assign cmd_done  = sclk_rise && state == TCTP_CMD && cmd_count == 4'(CMD_BITS - 1);
	assign soft_por  = cmd_done && cmd_full == CMD_SOFT_POR;
	assign start_req = cmd_done && cmd_full == CMD_START;
	assign stop_req  = cmd_done && cmd_full == CMD_STOP;
	// last needed bit of either write kind; busy must not pulse mid threshold
	assign wr_commit = sclk_rise && state == TCTP_WRITE && bit_count ==
		((cmd_shift == CMD_WRITE_CFG) ? 5'(CFG_BITS - 1) : 5'(THR_BITS - 1));
	assign res_code  = config_value[RES_HI_POS:RES_LO_POS];
	// 93.75 ms doubled per resolution step
	assign conv_len  = TIMER_W'(CONV_BASE) << res_code;

	// transaction framing and command decode
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state     <= TCTP_IDLE;
			cmd_shift <= 8'h00;
			cmd_count <= 4'h0;
			wr_shift  <= 12'h000;
			bit_count <= 5'h00;
		end
		else if (!sel_s)
		begin
			state     <= TCTP_CMD;
			cmd_count <= 4'h0;
			bit_count <= 5'h00;
		end
		else if (sclk_rise)
		begin
			case (state)
				TCTP_CMD:
				begin
					cmd_shift <= cmd_full;
					cmd_count <= cmd_count + 4'h1;
					bit_count <= 5'h00;
					if (cmd_count == 4'(CMD_BITS - 1))
					begin
						case (cmd_full)
							CMD_LOAD_HIGH, CMD_LOAD_LOW, CMD_WRITE_CFG:
								state <= TCTP_WRITE;
							CMD_READ_TEMP, CMD_FETCH_HIGH, CMD_FETCH_LOW, CMD_READ_CFG:
								state <= TCTP_READ;
							default:
								state <= TCTP_IDLE;
						endcase
					end
				end
				TCTP_WRITE:
				begin
					// bits past the needed count are dropped
					if (bit_count < 5'(THR_BITS))
					begin
						wr_shift  <= {dq_sync[1], wr_shift[11:1]};
						bit_count <= bit_count + 5'h01;
					end
				end
				TCTP_READ:
					state <= TCTP_READ;
				TCTP_IDLE:
					state <= TCTP_IDLE;
				default:
					state <= TCTP_IDLE;
			endcase
		end
	end

	// registers written from the link
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			high_threshold <= HIGH_RESET;
			low_threshold  <= LOW_RESET;
			config_value   <= CFG_RESET;
			thf            <= 1'b0;
			tlf            <= 1'b0;
			nv_timer       <= '0;
			nonvolatile_busy_flag <= 1'b0;
		end
		else if (soft_por)
		begin
			high_threshold <= HIGH_RESET;
			low_threshold  <= LOW_RESET;
			config_value   <= CFG_RESET;
			thf            <= 1'b0;
			tlf            <= 1'b0;
			nv_timer       <= '0;
			nonvolatile_busy_flag <= 1'b0;
		end
		else
		begin
			if (sel_s && sclk_rise && state == TCTP_WRITE && cmd_shift != CMD_WRITE_CFG
				&& bit_count == 5'(THR_BITS - 1))
			begin
				if (cmd_shift == CMD_LOAD_HIGH)
					high_threshold <= {dq_sync[1], wr_shift[11:1]};
				else
					low_threshold <= {dq_sync[1], wr_shift[11:1]};
				nv_timer <= TIMER_W'(NV_BASE);
			end
			else if (sel_s && sclk_rise && state == TCTP_WRITE && cmd_shift == CMD_WRITE_CFG
				&& bit_count == 5'(CFG_BITS - 1))
			begin
				// done and busy are read only; flags clear by writing zero
				config_value[RES_HI_POS:SHOT_POS] <= wr_shift[8:5];
				thf      <= thf & wr_shift[11];
				tlf      <= tlf & wr_shift[10];
				nv_timer <= TIMER_W'(NV_BASE);
			end
			else if (nv_timer != '0)
				nv_timer <= nv_timer - TIMER_W'(1);
			nonvolatile_busy_flag <= (nv_timer > TIMER_W'(1)) || wr_commit;
			config_value[DONE_POS] <= !(conv_timer != '0 || start_req);
			config_value[NVB_POS]  <= nv_timer > TIMER_W'(1);
			config_value[THF_POS]  <= thf;
			config_value[TLF_POS]  <= tlf;
		end
	end

	// conversion sequencing; result taken from the analog side when a pass ends
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			conv_timer      <= '0;
			conv_continuous <= 1'b0;
			converting      <= 1'b0;
			temp_result     <= TEMP_RESET;
		end
		else if (soft_por || stop_req)
		begin
			conv_timer      <= '0;
			conv_continuous <= 1'b0;
			converting      <= 1'b0;
			if (soft_por)
				temp_result <= TEMP_RESET;
		end
		else if (start_req)
		begin
			conv_timer      <= conv_len;
			conv_continuous <= !config_value[SHOT_POS];
			converting      <= 1'b1;
		end
		else if (conv_timer == TIMER_W'(1))
		begin
			// low bits beyond the chosen resolution read zero
			temp_result <= temp_sample & (16'hFFF0 << (2'h3 - res_code));
			conv_timer  <= conv_continuous ? conv_len : '0;
			converting  <= conv_continuous;
		end
		else if (conv_timer != '0)
			conv_timer <= conv_timer - TIMER_W'(1);
	end

	// read shifter: load after the command, drive on falling edges
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rd_shift <= 16'h0000;
			rd_len   <= 5'h00;
			dq_out   <= 1'b0;
			dq_oe    <= 1'b0;
		end
		else if (!sel_s)
		begin
			dq_oe  <= 1'b0;
			dq_out <= 1'b0;
		end
		else if (cmd_done)
		begin
			case (cmd_full)
				CMD_READ_TEMP:  rd_shift <= temp_result;
				CMD_FETCH_HIGH: rd_shift <= {4'h0, high_threshold};
				CMD_FETCH_LOW:  rd_shift <= {4'h0, low_threshold};
				CMD_READ_CFG:   rd_shift <= {8'h00, config_value};
				default:        rd_shift <= 16'h0000;
			endcase
			rd_len <= (cmd_full == CMD_READ_CFG) ? 5'(CFG_BITS) : 5'(WORD_BITS);
		end
		else if (state == TCTP_READ && sclk_fall)
		begin
			dq_oe    <= 1'b1;
			dq_out   <= (rd_len != 5'h00) ? rd_shift[0] : 1'b0;
			rd_shift <= {1'b0, rd_shift[15:1]};
			if (rd_len != 5'h00)
				rd_len <= rd_len - 5'h01;
		end
		else if (sclk_rise)
			dq_oe <= 1'b0;
	end

	property p_release_on_deselect;
		@(posedge sys_clk) disable iff (rst)
		!sel_s |=> !dq_oe;
	endproperty
	a_release_on_deselect: assert property (p_release_on_deselect)
		else $error("data driven while deselected");

	property p_drive_after_fall;
		@(posedge sys_clk) disable iff (rst)
		(state == TCTP_READ && sclk_fall && sel_s) |=> dq_oe;
	endproperty
	a_drive_after_fall: assert property (p_drive_after_fall)
		else $error("read bit not driven after falling edge");

	property p_release_after_rise;
		@(posedge sys_clk) disable iff (rst)
		(sclk_rise && !cmd_done) |=> !dq_oe;
	endproperty
	a_release_after_rise: assert property (p_release_after_rise)
		else $error("data line held after rising edge");

	property p_zero_fill;
		@(posedge sys_clk) disable iff (rst)
		(state == TCTP_READ && sclk_fall && sel_s && rd_len == 5'h00) |=> !dq_out;
	endproperty
	a_zero_fill: assert property (p_zero_fill)
		else $error("nonzero bit after read data");

	property p_start_runs;
		@(posedge sys_clk) disable iff (rst)
		start_req |=> converting ##1 !config_value[DONE_POS];
	endproperty
	a_start_runs: assert property (p_start_runs)
		else $error("start command did not begin conversion");

	property p_stop_halts;
		@(posedge sys_clk) disable iff (rst)
		stop_req |=> !converting && conv_timer == '0;
	endproperty
	a_stop_halts: assert property (p_stop_halts)
		else $error("stop command did not halt conversion");

	property p_por_restores;
		@(posedge sys_clk) disable iff (rst)
		soft_por |=> config_value == CFG_RESET && high_threshold == HIGH_RESET && !converting;
	endproperty
	a_por_restores: assert property (p_por_restores)
		else $error("software reset left state behind");

	property p_threshold_stable;
		@(posedge sys_clk) disable iff (rst)
		(state != TCTP_WRITE && !soft_por) |=> $stable(high_threshold) && $stable(low_threshold);
	endproperty
	a_threshold_stable: assert property (p_threshold_stable)
		else $error("threshold changed outside a full write");

	property p_busy_after_write;
		@(posedge sys_clk) disable iff (rst)
		$rose(nonvolatile_busy_flag) |-> ##2 config_value[NVB_POS];
	endproperty
	a_busy_after_write: assert property (p_busy_after_write)
		else $error("busy bit not shown after write");

	property p_done_low_while_timing;
		@(posedge sys_clk) disable iff (rst)
		(conv_timer != '0 && !soft_por) |=> !config_value[DONE_POS];
	endproperty
	a_done_low_while_timing: assert property (p_done_low_while_timing)
		else $error("done bit high during conversion");

	property p_done_high_when_idle;
		@(posedge sys_clk) disable iff (rst)
		(conv_timer == '0 && !start_req) |=> config_value[DONE_POS];
	endproperty
	a_done_high_when_idle: assert property (p_done_high_when_idle)
		else $error("done bit low with no conversion");

	property p_busy_while_timer;
		@(posedge sys_clk) disable iff (rst)
		(nv_timer > TIMER_W'(1) && !soft_por) |=> nonvolatile_busy_flag && config_value[NVB_POS];
	endproperty
	a_busy_while_timer: assert property (p_busy_while_timer)
		else $error("busy not shown while cell write runs");
endmodule : tctp_port
`default_nettype wire

/* testbench/tctp_master.sv */
`timescale 1ns/10ps
`default_nettype none
module tctp_master
(
	// system
	input  wire logic sys_clk,
	// link
	output logic      sel_pin,
	output logic      sclk_pin,
	output logic      dq_line,
	input  wire logic dq_out,
	input  wire logic dq_oe
);
	logic drv;
	logic bit_v;
	logic last = 1'b0;
	// no pull on the line: a released line toggles so stale data never passes
	assign dq_line = dq_oe ? dq_out : (drv ? bit_v : ~last);
	always_ff @(posedge sys_clk)
		last <= dq_line;
	initial
	begin
		sel_pin = 1'b0;
		sclk_pin = 1'b0;
		drv = 1'b0;
		bit_v = 1'b0;
	end
	task automatic half();
		repeat (4) @(posedge sys_clk);
		#1;
	endtask : half
	task automatic frame(input logic [7:0] cmd, input int nw, input logic [15:0] wd,
		input int nb, output logic [23:0] rd);
		rd = '0;
		half();
		sel_pin = 1'b1;
		half();
		for (int i = 0; i < nb; i++)
		begin
			drv = i < 8 + nw;
			bit_v = (i < 8) ? cmd[3'(i)] : wd[4'(i - 8)];
			half();
			if (i >= 8)
				rd[5'(i - 8)] = dq_line;
			sclk_pin = 1'b1;
			half();
			sclk_pin = 1'b0;
		end
		drv = 1'b0;
		half();
		sel_pin = 1'b0;
		half();
	endtask : frame
endmodule : tctp_master
`default_nettype wire

/* testbench/tctp_port_test.sv */
`timescale 1ns/10ps
`default_nettype none
module tctp_port_test;
	import tctp_pkg::*;
	localparam int CONV = 200;
	localparam int NV   = 200;
	logic        sys_clk;
	logic        rst;
	logic        sel_pin;
	logic        sclk_pin;
	logic        dq_line;
	logic        dq_out;
	logic        dq_oe;
	logic [15:0] temp_sample;
	logic        converting;
	logic        nonvolatile_busy_flag;
	logic [7:0]  config_value;
	logic [11:0] high_threshold;
	logic [11:0] low_threshold;
	logic [15:0] temp_result;
	logic [23:0] rd;
	int          errors = 0;
	int          n_tests = 0;
	tctp_port #(.CONV_BASE(CONV), .NV_BASE(NV)) dut
	(
		.sys_clk(sys_clk), .rst(rst), .sel_pin(sel_pin), .sclk_pin(sclk_pin),
		.dq_in(dq_line), .dq_out(dq_out), .dq_oe(dq_oe), .temp_sample(temp_sample),
		.converting(converting), .nonvolatile_busy_flag(nonvolatile_busy_flag),
		.config_value(config_value), .high_threshold(high_threshold),
		.low_threshold(low_threshold), .temp_result(temp_result)
	);
	tctp_master m
	(
		.sys_clk(sys_clk), .sel_pin(sel_pin), .sclk_pin(sclk_pin),
		.dq_line(dq_line), .dq_out(dq_out), .dq_oe(dq_oe)
	);
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic end_sim();
		$display("comparisons=%0d mismatches=%0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	initial
	begin
		for (int k = 0; k < 20000; k++)
			@(posedge sys_clk);
		errors++;
		end_sim();
	end
	initial
	begin
		rst = 1'b1;
		temp_sample = 16'h1917;
		cyc(2);
		rst = 1'b0;
		cyc(4);
		chk({16'h0, config_value}, 24'h00008C);
		m.frame(CMD_READ_CFG, 0, 16'h0, 32, rd);
		chk(rd, 24'h00008C);
		$display("test reset done");
		m.frame(CMD_LOAD_HIGH, 16, 16'hF5A3, 24, rd);
		chk({23'h0, nonvolatile_busy_flag}, 24'h1);
		chk({12'h0, high_threshold}, 24'h0005A3);
		cyc(NV + 10);
		chk({23'h0, nonvolatile_busy_flag}, 24'h0);
		m.frame(CMD_FETCH_HIGH, 0, 16'h0, 32, rd);
		chk(rd, 24'h0005A3);
		m.frame(CMD_LOAD_LOW, 8, 16'h00FF, 16, rd);
		chk({12'h0, low_threshold}, 24'h0);
		cyc(NV + 10);
		m.frame(CMD_LOAD_LOW, 12, 16'h07C3, 20, rd);
		chk({12'h0, low_threshold}, 24'h0007C3);
		cyc(NV + 10);
		m.frame(CMD_FETCH_LOW, 0, 16'h0, 32, rd);
		chk(rd, 24'h0007C3);
		$display("test thresholds done");
		m.frame(CMD_WRITE_CFG, 8, 16'h000D, 16, rd);
		chk({16'h0, config_value}, 24'h00009D);
		cyc(NV + 10);
		m.frame(CMD_START, 0, 16'h0, 8, rd);
		chk({23'h0, converting}, 24'h1);
		chk({23'h0, config_value[DONE_POS]}, 24'h0);
		for (int k = 0; k < 3000 && converting !== 1'b0; k++)
			cyc(1);
		cyc(2);
		chk({22'h0, config_value[DONE_POS], converting}, 24'h2);
		chk({8'h0, temp_result}, 24'h001910);
		m.frame(CMD_READ_TEMP, 0, 16'h0, 32, rd);
		chk(rd, 24'h001910);
		$display("test one shot done");
		m.frame(CMD_WRITE_CFG, 8, 16'h000C, 16, rd);
		cyc(NV + 10);
		m.frame(CMD_START, 0, 16'h0, 8, rd);
		cyc(2000);
		chk({23'h0, converting}, 24'h1);
		m.frame(CMD_STOP, 0, 16'h0, 8, rd);
		chk({23'h0, converting}, 24'h0);
		$display("test continuous done");
		m.frame(CMD_READ_CFG, 0, 16'h0, 10, rd);
		chk({23'h0, dq_oe}, 24'h0);
		m.frame(CMD_START, 0, 16'h0, 8, rd);
		m.frame(CMD_SOFT_POR, 0, 16'h0, 8, rd);
		chk({15'h0, converting, config_value}, 24'h00008C);
		m.frame(CMD_READ_CFG, 0, 16'h0, 32, rd);
		chk(rd, 24'h00008C);
		$display("test abort and reset done");
		end_sim();
	end
endmodule : tctp_port_test
`default_nettype wire
